/* File: src/mem_bus_pkg.sv */
// constants and carriers shared by the memory bus controller
package mem_bus_pkg;
	// register indices; byte address on the bus is four times the index
	localparam logic [19:0] IDX_RAMSZ = 20'h05326;
	localparam logic [19:0] IDX_WAIT = 20'h054B0;
	localparam logic [19:0] IDX_WPROT = 20'h27FFC;
	localparam logic [19:0] IDX_RPROT = 20'h27FFE;
	localparam logic [19:0] IDX_UNLOCK = 20'h05300;
	localparam logic [19:0] IDX_VBLO = 20'h05310;
	localparam logic [19:0] IDX_VBHI = 20'h05312;
	// field positions and reset values
	localparam int DBSEL_BIT = 8;
	localparam logic [7:0] UNLOCK_KEY = 8'h96;
	localparam logic [1:0] WAIT_RST = 2'h3;
	localparam logic [2:0] RAMSZ_RST = 3'h6;
	localparam logic [2:0] RAM_ACTUAL = 3'h6;
	localparam logic [7:0] PROT_ERASED = 8'hFF;
	localparam logic [23:0] VBASE_RST = 24'h008000;
	localparam logic [23:0] DBG_BASE0 = 24'h0FFC00;
	localparam logic [23:0] DBG_BASE1 = 24'h000000;
	// address map
	localparam logic [23:0] FLASH_LO = 24'h008000;
	localparam logic [23:0] FLASH_HI = 24'h027FFF;
	localparam logic [23:0] PERI1_LO = 24'h004000;
	localparam logic [23:0] PERI1_W16 = 24'h004200;
	localparam logic [23:0] PERI1_HI = 24'h0043FF;
	localparam logic [23:0] PERI2_LO = 24'h005000;
	localparam logic [23:0] PERI2_W16 = 24'h005300;
	localparam logic [23:0] PERI2_HI = 24'h005FFF;
	localparam logic [4:0] PROT_SECTOR = 5'h1F;
	localparam int AREA_LSB = 14;
	// usable RAM bytes, indexed by the size select code
	localparam logic [14:0] RAM_LIMIT [8] = '{15'h3000, 15'h2000, 15'h1000, 15'h0800,
		15'h0400, 15'h0200, 15'h4000, 15'h4000};
	// device widths in bits
	localparam logic [5:0] DW8 = 6'h08;
	localparam logic [5:0] DW16 = 6'h10;
	localparam logic [5:0] DW32 = 6'h20;
	// base clocks of one bus cycle with no wait: flash fetch, flash data read, any other cycle
	localparam logic [2:0] FETCH_BASE = 3'h1;
	localparam logic [2:0] DREAD_BASE = 3'h2;
	localparam logic [2:0] PLAIN_CYC = 3'h1;

	typedef enum logic [1:0] {RG_NONE = 2'h0, RG_RAM = 2'h1, RG_FLASH = 2'h2, RG_PERI = 2'h3} region_t;
	typedef enum logic [1:0] {SZ8 = 2'h0, SZ16 = 2'h1, SZ32 = 2'h2} acc_size_t;

	typedef struct packed {
		logic [23:0] addr;
		logic write;
		acc_size_t size;
		logic stack;
		logic [31:0] wdata;
	} data_req_t;

	typedef struct packed {
		logic req;
		logic [23:0] addr;
		logic write;
		logic [31:0] wdata;
		region_t region;
	} mem_port_t;
endpackage : mem_bus_pkg

/* File: src/mem_bus_ctrl.sv */
// memory-side bus controller: wait states, access splitting, protection, registers
//
// Behaviour
// - non-flash bus cycles take one clock
// - flash fetch takes one to three clocks
// - flash data read takes two to four
// - split accesses by target device width
// - 32-bit access zeroes top byte
// - stacking moves full word with status
// - fetch waits behind data access to same flash or RAM
// - flash decoded 0x8000 to 0x27fff
// - vector base resets 0x8000, software relocatable
// - write-protected area blocks writes and erases
// - read-protected data reads return zero
// - protect bits active low, programmed to zero
// - write-protect bits 0-6, bit 7 one
// - read-protect bits 1-7, bit 0 reserved
// - only protect-sector erase or reset clears protection
// - wait code resets 3, maps to waits
// - each wait adds one clock
// - RAM size select limits RAM, resets 6
// - size writes need unlock key 0x96
// - debug base select resets to 0xffc00
// - decode both peripheral windows with widths
module mem_bus_ctrl
	import mem_bus_pkg::*;
(
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic FETCH_REQ_I,
	input wire logic [23:0] FETCH_ADDR_I,
	output logic FETCH_DONE_O,
	output logic [15:0] FETCH_DATA_O,
	input wire logic DATA_REQ_I,
	input wire data_req_t DATA_INFO_I,
	output logic DATA_DONE_O,
	output logic [31:0] DATA_RDATA_O,
	output mem_port_t IMEM_O,
	input wire logic [31:0] IMEM_RDATA_I,
	output mem_port_t DMEM_O,
	input wire logic [31:0] DMEM_RDATA_I,
	input wire logic ERASE_REQ_I,
	input wire logic [4:0] ERASE_SECTOR_I,
	output logic ERASE_GO_O,
	output logic [23:0] VECTOR_BASE_O,
	output logic [23:0] DEBUG_BASE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);

	typedef enum logic [2:0] {D_IDLE = 3'h1, D_XFER = 3'h2, D_DONE = 3'h4} dstate_t;
	typedef enum logic [2:0] {F_IDLE = 3'h1, F_RUN = 3'h2, F_DONE = 3'h4} fstate_t;

	logic ph_valid_ff, ph_write_ff, rd_done_ff, wr_en;
	logic [19:0] ph_idx_ff;
	logic [31:0] hrdata_ff, rd_val;
	logic [7:0] unlock_ff, wprot_ff, rprot_ff;
	logic [2:0] ram_sel_ff;
	logic [1:0] wait_ff;
	logic [23:0] vbase_ff, dbase_ff;
	logic erase_go_ff;

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// flash wait count code to inserted waits
	function automatic logic [2:0] wait_of(input logic [1:0] code);
		case (code)
			2'h1: wait_of = 3'h0;
			2'h2: wait_of = 3'h1;
			default: wait_of = 3'h2; // reserved code: take the slowest, safe at any clock
		endcase
	endfunction : wait_of

	function automatic region_t region_of(input logic [23:0] a, input logic [2:0] sel);
		if (a < {9'h000, RAM_LIMIT[sel]}) region_of = RG_RAM;
		else if (a >= FLASH_LO && a <= FLASH_HI) region_of = RG_FLASH;
		else if ((a >= PERI1_LO && a <= PERI1_HI) || (a >= PERI2_LO && a <= PERI2_HI)) region_of = RG_PERI;
		else region_of = RG_NONE;
	endfunction : region_of

	function automatic logic [5:0] dev_bits(input logic [23:0] a, input region_t rg);
		case (rg)
			RG_FLASH: dev_bits = DW16;
			RG_PERI: dev_bits = ((a >= PERI1_W16 && a <= PERI1_HI) || a >= PERI2_W16) ? DW16 : DW8;
			default: dev_bits = DW32;
		endcase
	endfunction : dev_bits

	// transfers per access by device width
	function automatic logic [2:0] beats_of(input acc_size_t sz, input logic [5:0] dw);
		beats_of = 3'h1;
		if (dw == DW8 && sz == SZ16) beats_of = 3'h2;
		if (dw == DW8 && sz == SZ32) beats_of = 3'h4;
		if (dw == DW16 && sz == SZ32) beats_of = 3'h2;
	endfunction : beats_of

	// clocks per bus cycle; only flash reads are stretched
	function automatic logic [2:0] cyc_of(input region_t rg, input logic [2:0] base, input logic [1:0] code);
		cyc_of = (rg == RG_FLASH) ? base + wait_of(code) : PLAIN_CYC;
	endfunction : cyc_of

	function automatic logic [2:0] area_of(input logic [23:0] a);
		logic [23:0] d;
		d = a - FLASH_LO;
		area_of = d[AREA_LSB+2:AREA_LSB];
	endfunction : area_of

	// area 7 has no write-protect bit, area 0 no read-protect bit
	function automatic logic wp_on(input logic [2:0] ar, input logic [7:0] w);
		wp_on = (ar != 3'h7) && !w[ar];
	endfunction : wp_on

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite register slave; reads take one wait so a write just before is seen

	assign wr_en = ph_valid_ff && ph_write_ff;
	assign HREADYOUT_O = !(ph_valid_ff && !ph_write_ff && !rd_done_ff);
	assign HRESP_O = 1'h0;
	assign HRDATA_O = hrdata_ff;

	// address phase capture; unaligned or out-of-range addresses are dropped
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ph_valid_ff <= 1'h0;
			ph_write_ff <= 1'h0;
			ph_idx_ff <= 20'h00000;
		end else if (HREADY_I) begin
			ph_valid_ff <= HSEL_I && HTRANS_I[1] && HADDR_I[31:22] == 10'h000 && HADDR_I[1:0] == 2'h0;
			ph_write_ff <= HWRITE_I;
			ph_idx_ff <= HADDR_I[21:2];
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rd_done_ff <= 1'h0;
			hrdata_ff <= 32'h00000000;
		end else begin
			rd_done_ff <= ph_valid_ff && !ph_write_ff && !rd_done_ff;
			if (ph_valid_ff && !ph_write_ff && !rd_done_ff) hrdata_ff <= rd_val;
		end
	end

	// read mux; unmapped indices read zero
	always_comb begin
		case (ph_idx_ff)
			IDX_RAMSZ: rd_val = {23'h000000, dbase_ff == DBG_BASE1, 1'h0, RAM_ACTUAL, 1'h0, ram_sel_ff};
			IDX_WAIT: rd_val = {30'h00000000, wait_ff};
			IDX_WPROT: rd_val = {24'h000000, 1'h1, wprot_ff[6:0]};
			IDX_RPROT: rd_val = {24'h000000, rprot_ff};
			IDX_UNLOCK: rd_val = {24'h000000, unlock_ff};
			IDX_VBLO: rd_val = {16'h0000, vbase_ff[15:0]};
			IDX_VBHI: rd_val = {24'h000000, vbase_ff[23:16]};
			default: rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) unlock_ff <= 8'h00;
		else if (wr_en && ph_idx_ff == IDX_UNLOCK) unlock_ff <= HWDATA_I[7:0];
	end

	// size and debug base only change while the unlock key stands
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ram_sel_ff <= RAMSZ_RST;
			dbase_ff <= DBG_BASE0;
		end else if (wr_en && ph_idx_ff == IDX_RAMSZ && unlock_ff == UNLOCK_KEY) begin
			ram_sel_ff <= HWDATA_I[2:0];
			dbase_ff <= HWDATA_I[DBSEL_BIT] ? DBG_BASE1 : DBG_BASE0;
		end
	end

	a_size_lock: assert property (wr_en && ph_idx_ff == IDX_RAMSZ && unlock_ff != UNLOCK_KEY
		|=> ram_sel_ff == $past(ram_sel_ff)) else $error("ram size changed without unlock key");

	always_ff @(posedge CLK_I) begin
		if (SRST_I) wait_ff <= WAIT_RST;
		else if (wr_en && ph_idx_ff == IDX_WAIT) wait_ff <= HWDATA_I[1:0];
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) vbase_ff <= VBASE_RST;
		else if (wr_en && ph_idx_ff == IDX_VBLO) vbase_ff[15:0] <= HWDATA_I[15:0];
		else if (wr_en && ph_idx_ff == IDX_VBHI) vbase_ff[23:16] <= HWDATA_I[7:0];
	end

	assign VECTOR_BASE_O = vbase_ff;
	assign DEBUG_BASE_O = dbase_ff;

	// programming only pulls bits to zero; the protect-sector erase restores them
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			wprot_ff <= PROT_ERASED;
			rprot_ff <= PROT_ERASED;
		end else if (ERASE_REQ_I && ERASE_SECTOR_I == PROT_SECTOR) begin
			wprot_ff <= PROT_ERASED;
			rprot_ff <= PROT_ERASED;
		end else if (wr_en && ph_idx_ff == IDX_WPROT) wprot_ff <= wprot_ff & HWDATA_I[7:0];
		else if (wr_en && ph_idx_ff == IDX_RPROT) rprot_ff <= rprot_ff & HWDATA_I[7:0];
	end

	// sector erase is gated by the area's write protection
	always_ff @(posedge CLK_I) begin
		if (SRST_I) erase_go_ff <= 1'h0;
		else erase_go_ff <= ERASE_REQ_I && (ERASE_SECTOR_I == PROT_SECTOR || !wp_on(ERASE_SECTOR_I[4:2], wprot_ff));
	end
	assign ERASE_GO_O = erase_go_ff;

	a_erase_restore: assert property (ERASE_REQ_I && ERASE_SECTOR_I == PROT_SECTOR
		|=> wprot_ff == PROT_ERASED && rprot_ff == PROT_ERASED && ERASE_GO_O)
		else $error("protect sector erase did not restore protect words");

	////////////////////////////////////////////////////////////////////////////
	// data access engine

	dstate_t d_state_ff;
	data_req_t d_req_ff;
	region_t d_rg_ff, n_rg;
	logic [5:0] d_dw_ff, d_sh_ff, n_dw;
	logic [2:0] d_beats_ff, d_beat_ff, d_cyc_ff, d_cnt_ff;
	logic d_rp_ff, d_end, d_last;
	logic [23:0] d_addr_ff;
	logic [31:0] d_wsh_ff, d_acc_ff, n_acc, n_wd, chunk;

	// decode of a new request; a blocked flash write becomes a dead cycle
	always_comb begin
		n_rg = region_of(DATA_INFO_I.addr, ram_sel_ff);
		if (DATA_INFO_I.write && n_rg == RG_FLASH && wp_on(area_of(DATA_INFO_I.addr), wprot_ff)) n_rg = RG_NONE;
		n_dw = dev_bits(DATA_INFO_I.addr, n_rg);
		n_wd = DATA_INFO_I.wdata;
		if (DATA_INFO_I.size == SZ32 && !DATA_INFO_I.stack) n_wd[31:24] = 8'h00; // stacking keeps status
	end

	assign d_end = d_state_ff == D_XFER && d_cnt_ff == d_cyc_ff - 3'h1;
	assign d_last = d_beat_ff == d_beats_ff - 3'h1;

	// merge the beat's lanes into the result at the running shift
	always_comb begin
		chunk = (d_rg_ff == RG_NONE) ? 32'h00000000 : DMEM_RDATA_I;
		if (d_dw_ff == DW8) chunk = chunk & 32'h000000FF;
		else if (d_dw_ff == DW16) chunk = chunk & 32'h0000FFFF;
		n_acc = d_acc_ff | (chunk << d_sh_ff);
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) d_state_ff <= D_IDLE;
		else begin
			case (d_state_ff)
				D_IDLE: if (DATA_REQ_I) d_state_ff <= D_XFER;
				D_XFER: if (d_end && d_last) d_state_ff <= D_DONE;
				D_DONE: d_state_ff <= D_IDLE;
				default: d_state_ff <= D_IDLE;
			endcase
		end
	end

	// per-access context and beat stepping
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			d_req_ff <= '0;
			d_rg_ff <= RG_NONE;
			d_dw_ff <= DW32;
			d_beats_ff <= 3'h1;
			d_beat_ff <= 3'h0;
			d_cyc_ff <= PLAIN_CYC;
			d_cnt_ff <= 3'h0;
			d_rp_ff <= 1'h0;
			d_addr_ff <= 24'h000000;
			d_sh_ff <= 6'h00;
			d_wsh_ff <= 32'h00000000;
			d_acc_ff <= 32'h00000000;
		end else if (d_state_ff == D_IDLE && DATA_REQ_I) begin
			d_req_ff <= DATA_INFO_I;
			d_rg_ff <= n_rg;
			d_dw_ff <= n_dw;
			d_beats_ff <= beats_of(DATA_INFO_I.size, n_dw);
			d_beat_ff <= 3'h0;
			d_cyc_ff <= DATA_INFO_I.write ? PLAIN_CYC : cyc_of(n_rg, DREAD_BASE, wait_ff);
			d_cnt_ff <= 3'h0;
			d_rp_ff <= n_rg == RG_FLASH && area_of(DATA_INFO_I.addr) != 3'h0
				&& !rprot_ff[area_of(DATA_INFO_I.addr)];
			d_addr_ff <= DATA_INFO_I.addr;
			d_sh_ff <= 6'h00;
			d_wsh_ff <= n_wd;
			d_acc_ff <= 32'h00000000;
		end else if (d_end && !d_last) begin
			d_beat_ff <= d_beat_ff + 3'h1;
			d_cnt_ff <= 3'h0;
			d_addr_ff <= d_addr_ff + {21'h000000, d_dw_ff[5:3]};
			d_sh_ff <= d_sh_ff + d_dw_ff;
			d_wsh_ff <= d_wsh_ff >> d_dw_ff;
			d_acc_ff <= n_acc;
		end else if (d_state_ff == D_XFER) d_cnt_ff <= d_cnt_ff + 3'h1;
	end

	// final word: protected reads give zero, 32-bit non-stacking reads drop the top byte
	logic [31:0] d_out_ff;
	always_ff @(posedge CLK_I) begin
		if (SRST_I) d_out_ff <= 32'h00000000;
		else if (d_end && d_last) begin
			if (d_rp_ff && !d_req_ff.write) d_out_ff <= 32'h00000000;
			else if (d_req_ff.size == SZ32 && !d_req_ff.stack) d_out_ff <= {8'h00, n_acc[23:0]};
			else d_out_ff <= n_acc;
		end
	end

	assign DATA_DONE_O = d_state_ff == D_DONE;
	assign DATA_RDATA_O = d_out_ff;
	assign DMEM_O = '{req: d_state_ff == D_XFER && d_rg_ff != RG_NONE, addr: d_addr_ff,
		write: d_req_ff.write, wdata: d_wsh_ff, region: d_rg_ff};

	a_data_one_clk: assert property (d_end && d_rg_ff != RG_FLASH |-> d_cnt_ff == 3'h0)
		else $error("non-flash data bus cycle not one clock");
	a_flash_read_len: assert property (d_end && d_rg_ff == RG_FLASH && !d_req_ff.write
		|-> d_cnt_ff == ((wait_ff == 2'h1) ? 3'h1 : (wait_ff == 2'h2) ? 3'h2 : 3'h3))
		else $error("flash data read length wrong for wait setting");
	a_split_count: assert property (DATA_DONE_O && d_dw_ff == DW8 && d_req_ff.size == SZ32
		|-> d_beat_ff == 3'h3 && $past(DMEM_O.req || d_rg_ff == RG_NONE, 4))
		else $error("8-bit device 32-bit access not four transfers");
	a_top_byte_drop: assert property (DATA_DONE_O && !d_req_ff.write && d_req_ff.size == SZ32
		&& !d_req_ff.stack |-> DATA_RDATA_O[31:24] == 8'h00) else $error("top byte of 32-bit read kept");
	a_read_prot_zero: assert property (DATA_DONE_O && d_rp_ff && !d_req_ff.write
		|-> DATA_RDATA_O == 32'h00000000) else $error("read-protected data not zero");
	a_write_prot: assert property (DMEM_O.req && DMEM_O.write && DMEM_O.region == RG_FLASH
		|-> !wp_on(area_of(DMEM_O.addr), wprot_ff)) else $error("write reached protected flash area");

	////////////////////////////////////////////////////////////////////////////
	// instruction fetch engine; yields to data in the same flash or RAM

	fstate_t f_state_ff;
	region_t f_rg_ff, n_frg;
	logic [23:0] f_addr_ff;
	logic [2:0] f_cyc_ff, f_cnt_ff;
	logic [15:0] f_data_ff;
	logic f_clash, f_go, f_end;

	assign n_frg = region_of(FETCH_ADDR_I, ram_sel_ff);
	// data has priority, so a clash lengthens the fetch by the data bus cycles
	assign f_clash = (f_rg_ff == RG_FLASH || f_rg_ff == RG_RAM)
		&& ((d_state_ff == D_XFER && d_rg_ff == f_rg_ff)
		|| (d_state_ff == D_IDLE && DATA_REQ_I && n_rg == f_rg_ff));
	assign f_go = f_state_ff == F_RUN && !f_clash;
	assign f_end = f_go && f_cnt_ff == f_cyc_ff - 3'h1;

	always_ff @(posedge CLK_I) begin
		if (SRST_I) f_state_ff <= F_IDLE;
		else begin
			case (f_state_ff)
				F_IDLE: if (FETCH_REQ_I) f_state_ff <= F_RUN;
				F_RUN: if (f_end) f_state_ff <= F_DONE;
				F_DONE: f_state_ff <= F_IDLE;
				default: f_state_ff <= F_IDLE;
			endcase
		end
	end

	// fetches ignore read protection and return the array word, or zero when unmapped
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			f_rg_ff <= RG_NONE;
			f_addr_ff <= 24'h000000;
			f_cyc_ff <= PLAIN_CYC;
			f_cnt_ff <= 3'h0;
			f_data_ff <= 16'h0000;
		end else if (f_state_ff == F_IDLE && FETCH_REQ_I) begin
			f_rg_ff <= n_frg;
			f_addr_ff <= FETCH_ADDR_I;
			f_cyc_ff <= cyc_of(n_frg, FETCH_BASE, wait_ff);
			f_cnt_ff <= 3'h0;
		end else if (f_go) begin
			f_cnt_ff <= f_cnt_ff + 3'h1;
			if (f_end && f_rg_ff == RG_NONE) f_data_ff <= 16'h0000;
			else if (f_end && f_rg_ff == RG_RAM && f_addr_ff[1]) f_data_ff <= IMEM_RDATA_I[31:16];
			else if (f_end) f_data_ff <= IMEM_RDATA_I[15:0];
		end
	end

	assign FETCH_DONE_O = f_state_ff == F_DONE;
	assign FETCH_DATA_O = f_data_ff;
	assign IMEM_O = '{req: f_go && f_rg_ff != RG_NONE, addr: f_addr_ff, write: 1'h0,
		wdata: 32'h00000000, region: f_rg_ff};

	a_fetch_len: assert property (FETCH_DONE_O && f_rg_ff == RG_FLASH
		|-> f_cnt_ff == ((wait_ff == 2'h1) ? 3'h1 : (wait_ff == 2'h2) ? 3'h2 : 3'h3))
		else $error("flash fetch length wrong for wait setting");
	a_fetch_one_clk: assert property (FETCH_DONE_O && f_rg_ff != RG_FLASH |-> f_cnt_ff == 3'h1)
		else $error("non-flash fetch not one clock");
	a_no_shared_area: assert property (IMEM_O.req && DMEM_O.req
		|-> IMEM_O.region != DMEM_O.region || IMEM_O.region == RG_PERI)
		else $error("fetch and data hit the same array together");
endmodule : mem_bus_ctrl

/* File: testbench/mem_model.sv */
// memory model standing on one fetch or data port of the controller
module mem_model
	import mem_bus_pkg::*;
(
	input wire logic clk_i,
	input wire mem_port_t port_i,
	input wire logic clear_i,
	output logic [31:0] rdata_o,
	output logic seen_o,
	output logic [23:0] last_addr_o,
	output logic [31:0] last_wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] held_ff = 32'h00000000;

	////////////////////////////////////////////////////////////////
	// address-tagged word while requested; inverse of last word when released,
	// so a controller sampling outside its transfer never gets a lucky match
	assign rdata_o = port_i.req ? {8'hC3, port_i.addr} : ~held_ff;

	// remember activity and the last write so the bench can judge splitting
	always_ff @(posedge clk_i) begin
		// hold the last driven word so the released value stays its steady inverse
		if (port_i.req) begin
			held_ff <= rdata_o;
		end
		if (clear_i) begin
			seen_o <= 1'b0;
		end else if (port_i.req) begin
			seen_o <= 1'b1;
		end
		if (port_i.req && port_i.write) begin
			last_addr_o <= port_i.addr;
			last_wdata_o <= port_i.wdata;
		end
	end
endmodule : mem_model

/* File: testbench/memory_bus_flash_ram_access_test.sv */
// self-checking bench for the memory bus controller
module memory_bus_flash_ram_access_test
	import mem_bus_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, srst, hsel, hwrite, hreadyout, hresp, clr, dseen;
	logic [31:0] haddr, hwdata, hrdata, drdata, imem_rd, dmem_rd, dlast_w;
	logic [1:0] htrans;
	logic fetch_req, fetch_done, data_req, data_done, erase_req, erase_go;
	logic [23:0] fetch_addr, vbase, dbase, dlast_a;
	logic [15:0] fetch_data;
	logic [4:0] erase_sec;
	data_req_t dinfo;
	mem_port_t imem, dmem;
	int n_errors = 0;
	int total_checks = 0;
	// usable RAM bytes for size codes 0..5
	logic [23:0] lims [6] = '{24'h003000, 24'h002000, 24'h001000, 24'h000800, 24'h000400, 24'h000200};

	mem_bus_ctrl i_mem_bus_ctrl(.CLK_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
		.HREADYOUT_O(hreadyout), .HRESP_O(hresp), .FETCH_REQ_I(fetch_req), .FETCH_ADDR_I(fetch_addr),
		.FETCH_DONE_O(fetch_done), .FETCH_DATA_O(fetch_data), .DATA_REQ_I(data_req), .DATA_INFO_I(dinfo),
		.DATA_DONE_O(data_done), .DATA_RDATA_O(drdata), .IMEM_O(imem), .IMEM_RDATA_I(imem_rd), .DMEM_O(dmem),
		.DMEM_RDATA_I(dmem_rd), .ERASE_REQ_I(erase_req), .ERASE_SECTOR_I(erase_sec), .ERASE_GO_O(erase_go),
		.VECTOR_BASE_O(vbase), .DEBUG_BASE_O(dbase));
	mem_model i_imem_model(.clk_i(clk), .port_i(imem), .clear_i(1'b0), .rdata_o(imem_rd), .seen_o(),
		.last_addr_o(), .last_wdata_o());
	mem_model i_dmem_model(.clk_i(clk), .port_i(dmem), .clear_i(clr), .rdata_o(dmem_rd), .seen_o(dseen),
		.last_addr_o(dlast_a), .last_wdata_o(dlast_w));

	////////////////////////////////////////////////////////////////
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// one AHB single transfer; address phase held until hready is sampled high
	task automatic ahb(input logic [19:0] idx, input logic wr, input logic [31:0] d, input logic [31:0] exp);
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {10'h000, idx, 2'h0};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		if (wr == 1'b0) chk(hrdata, exp, "register read");
		chk({31'h0, hresp}, 32'h0, "bus response");
	endtask : ahb

	// data access; es 2 means the memory-request check is skipped
	task automatic dacc(input logic [23:0] a, input logic w, input acc_size_t sz, input logic stk,
		input logic [31:0] wd, input int exp_cnt, input logic [31:0] exp_rd, input int es);
		int cnt;
		cnt = 0;
		data_req <= 1'b1;
		dinfo <= '{addr: a, write: w, size: sz, stack: stk, wdata: wd};
		clr <= 1'b1;
		do begin
			@(posedge clk);
			clr <= 1'b0;
			cnt++;
		end while (data_done !== 1'b1 && cnt < 100);
		data_req <= 1'b0;
		chk(cnt, exp_cnt, "data cycles");
		if (w == 1'b0) chk(drdata, exp_rd, "data read");
		if (es < 2) chk({31'h0, dseen}, es, "memory request");
		// request drops for one cycle before the next may start
		@(posedge clk);
	endtask : dacc

	task automatic fetch(input logic [23:0] a, input int exp_cnt);
		int cnt;
		cnt = 0;
		fetch_req <= 1'b1;
		fetch_addr <= a;
		do begin
			@(posedge clk);
			cnt++;
		end while (fetch_done !== 1'b1 && cnt < 100);
		fetch_req <= 1'b0;
		chk(cnt, exp_cnt, "fetch cycles");
		chk({16'h0, fetch_data}, {16'h0, a[15:0]}, "fetch data");
		@(posedge clk);
	endtask : fetch

	task automatic erase(input logic [4:0] sec, input logic exp_go);
		erase_req <= 1'b1;
		erase_sec <= sec;
		@(posedge clk);
		erase_req <= 1'b0;
		@(posedge clk);
		chk({31'h0, erase_go}, {31'h0, exp_go}, "erase go");
	endtask : erase

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////
	// watchdog: all tests need well under 50000 cycles
	initial begin
		#200000;
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end

	// main sequence
	initial begin
		srst = 1'b1;
		{hsel, hwrite, fetch_req, data_req, erase_req, clr} = 6'h00;
		{haddr, hwdata} = 64'h0;
		htrans = 2'h0;
		fetch_addr = 24'h000000;
		dinfo = '0;
		erase_sec = 5'h00;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		hsel <= 1'b1;
		@(posedge clk);
		chk({8'h00, vbase}, 32'h00008000, "vector base");
		chk({8'h00, dbase}, 32'h000FFC00, "debug base");
		ahb(IDX_WAIT, 1'b0, 0, 32'h3);
		ahb(IDX_RAMSZ, 1'b0, 0, 32'h66);
		ahb(IDX_WPROT, 1'b0, 0, 32'hFF);
		ahb(IDX_RPROT, 1'b0, 0, 32'hFF);
		ahb(20'h05400, 1'b0, 0, 32'h0);
		$display("test reset values done");
		// every wait code, fetch and data read from flash
		for (int c = 0; c < 4; c++) begin
			ahb(IDX_WAIT, 1'b1, c, 0);
			ahb(IDX_WAIT, 1'b0, 0, c);
			fetch(24'h00A000, (c == 0) ? 5 : c + 2);
			dacc(24'h00A004, 1'b0, SZ16, 1'b0, 0, (c == 0) ? 6 : c + 3, 32'hA004, 1);
		end
		dacc(24'h009000, 1'b0, SZ32, 1'b1, 0, 10, 32'h90029000, 1);
		dacc(24'h009000, 1'b0, SZ32, 1'b0, 0, 10, 32'h00029000, 1);
		$display("test flash waits done");
		// splitting by device width
		dacc(24'h000100, 1'b0, SZ32, 1'b0, 0, 3, 32'h00000100, 1);
		dacc(24'h000100, 1'b0, SZ32, 1'b1, 0, 3, 32'hC3000100, 1);
		dacc(24'h005000, 1'b0, SZ32, 1'b0, 0, 6, 32'h00020100, 1);
		dacc(24'h005002, 1'b0, SZ16, 1'b0, 0, 4, 32'h00000302, 1);
		dacc(24'h005001, 1'b0, SZ8, 1'b0, 0, 3, 32'h00000001, 1);
		dacc(24'h004200, 1'b0, SZ32, 1'b0, 0, 4, 32'h00024200, 1);
		dacc(24'h004202, 1'b0, SZ16, 1'b0, 0, 3, 32'h00004202, 1);
		dacc(24'h004000, 1'b0, SZ16, 1'b0, 0, 4, 32'h00000100, 1);
		dacc(24'h005300, 1'b0, SZ32, 1'b0, 0, 4, 32'h00025300, 1);
		dacc(24'h000100, 1'b1, SZ32, 1'b0, 32'hAB123456, 3, 0, 1);
		chk(dlast_w, 32'h00123456, "ram write");
		dacc(24'h000100, 1'b1, SZ32, 1'b1, 32'hAB123456, 3, 0, 1);
		chk(dlast_w, 32'hAB123456, "stack write");
		dacc(24'h005000, 1'b1, SZ32, 1'b1, 32'hAB123456, 6, 0, 1);
		chk({dlast_a, dlast_w[7:0]}, 32'h005003AB, "last byte transfer");
		$display("test splitting done");
		// fetch and data on the same memory, then on different ones
		ahb(IDX_WAIT, 1'b1, 1, 0);
		fork
			fetch(24'h00A000, 5);
			dacc(24'h00B000, 1'b0, SZ16, 1'b0, 0, 4, 32'h0000B000, 1);
		join
		fork
			fetch(24'h000200, 4);
			dacc(24'h000300, 1'b0, SZ32, 1'b0, 0, 3, 32'h00000300, 1);
		join
		fork
			fetch(24'h00A000, 3);
			dacc(24'h000300, 1'b0, SZ32, 1'b0, 0, 3, 32'h00000300, 1);
		join
		$display("test fetch arbitration done");
		// protection; read-protect bit 0 is kept one
		ahb(IDX_RPROT, 1'b1, 32'hFD, 0);
		ahb(IDX_RPROT, 1'b0, 0, 32'hFD);
		dacc(24'h00C000, 1'b0, SZ16, 1'b0, 0, 4, 32'h0, 2);
		fetch(24'h00C000, 3);
		dacc(24'h010004, 1'b0, SZ16, 1'b0, 0, 4, 32'h0004, 1);
		ahb(IDX_WPROT, 1'b1, 32'h00, 0);
		ahb(IDX_WPROT, 1'b0, 0, 32'h80);
		dacc(24'h008000, 1'b1, SZ16, 1'b0, 32'h1234, 3, 0, 0);
		dacc(24'h024000, 1'b1, SZ16, 1'b0, 32'h1234, 3, 0, 1);
		ahb(IDX_WPROT, 1'b1, 32'hFF, 0);
		ahb(IDX_WPROT, 1'b0, 0, 32'h80);
		erase(5'h00, 1'b0);
		erase(5'h1C, 1'b1);
		erase(5'h1F, 1'b1);
		ahb(IDX_WPROT, 1'b0, 0, 32'hFF);
		ahb(IDX_RPROT, 1'b0, 0, 32'hFF);
		dacc(24'h00C000, 1'b0, SZ16, 1'b0, 0, 4, 32'hC000, 1);
		$display("test protection done");
		// RAM size needs the unlock key first
		ahb(IDX_RAMSZ, 1'b1, 32'h105, 0);
		ahb(IDX_RAMSZ, 1'b0, 0, 32'h66);
		ahb(IDX_UNLOCK, 1'b1, 32'h96, 0);
		for (int c = 0; c < 6; c++) begin
			ahb(IDX_RAMSZ, 1'b1, 32'h100 | c, 0);
			ahb(IDX_RAMSZ, 1'b0, 0, 32'h160 | c);
			dacc(lims[c] - 24'h4, 1'b0, SZ32, 1'b0, 0, 3, {8'h00, lims[c] - 24'h4}, 1);
			dacc(lims[c], 1'b0, SZ32, 1'b0, 0, 3, 32'h0, 0);
		end
		chk({8'h00, dbase}, 32'h0, "debug base");
		ahb(IDX_VBLO, 1'b1, 32'h1234, 0);
		ahb(IDX_VBHI, 1'b1, 32'h02, 0);
		@(posedge clk);
		chk({8'h00, vbase}, 32'h00021234, "vector base");
		// reset in mid-run must bring the bases, RAM size and wait code back
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk({8'h00, vbase}, 32'h00008000, "vector base after reset");
		chk({8'h00, dbase}, 32'h000FFC00, "debug base after reset");
		ahb(IDX_RAMSZ, 1'b0, 0, 32'h66);
		ahb(IDX_WAIT, 1'b0, 0, 32'h3);
		$display("test ram size and bases done");
		end_sim();
	end
endmodule : memory_bus_flash_ram_access_test
